/* File: clock_powersave_reset_ctrl.sv */
// clock generation, power-save clocking and reset sequencing with AXI4-Lite registers
// assumes res_n, straps, crystal_in and the address/data bus are synchronous to clk_sys
`timescale 1ns/10ps

// What this block does
// - internal clock follows crystal at same rate, near even duty, no doubled input.
// - power-on reset holds the internal clock generator in reset.
// - two clock outputs enabled separately by config bits 8 and 10.
// - each clock output may run at full rate or at power-save rate.
// - in power-save the core and peripheral clocks run slower.
// - interrupt in power-save restores normal rate at internal rising edge in phase t3.
// - while reset is low, execution and local bus activity are halted.
// - after release and interval, fetch starts at ffff0 with upper select, three waits.
// - reset loads register defaults and resets the watchdog timer.
// - half-clock strap low at reset release runs crystal divided by two; pll_reset stays low, generator not disabled.
// - both emulation straps low at release tristate all pins until next reset.
// - address/data bus captured into reset configuration while reset is low, then kept.
module clock_powersave_reset_ctrl
	import clock_powersave_reset_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic res_n,
	input wire logic crystal_in,
	input wire logic half_clock_strap_n,
	input wire logic emulation_strap0_n,
	input wire logic emulation_strap1_n,
	input wire logic [15:0] ad_in,
	input wire logic irq,
	input wire logic bus_phase_t3,
	output logic internal_clk,
	output logic core_clk,
	output logic periph_clk,
	output logic clkout_a,
	output logic clkout_b,
	output logic pll_reset,
	output logic cpu_halt,
	output logic bus_halt,
	output logic watchdog_timer_reset,
	output logic fetch_start,
	output logic [19:0] fetch_addr,
	output logic upper_select,
	output logic [1:0] fetch_wait_states,
	output logic pins_tristate,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	rst_state_t state_reg;
	rst_state_t state_next;
	logic [PROC_CNT_W-1:0] proc_cnt_reg;
	logic res_n_prev_reg;
	logic crystal_prev_reg;
	logic half_clock_reg;
	logic emulation_reg;
	logic [15:0] reset_config_reg;
	logic [31:0] system_config_reg;
	logic [DIV_W-1:0] psave_divisor_reg;
	logic int_clk_reg;
	logic [DIV_W-1:0] div_cnt_reg;
	logic psave_clk_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	// reset sequencing
	wire res_rise = res_n && !res_n_prev_reg;
	wire in_hold = (state_reg == st_hold);
	wire proc_done = (state_reg == st_proc) && (proc_cnt_reg == PROC_CNT_ONE);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			st_hold: begin
				if (res_n)
					state_next = st_proc;
			end
			st_proc: begin
				if (!res_n)
					state_next = st_hold;
				else if (proc_done)
					state_next = st_run;
			end
			st_run: begin
				if (!res_n)
					state_next = st_hold;
			end
			default: begin
				state_next = st_hold;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= st_hold;
			proc_cnt_reg <= PROC_CNT_ZERO;
			res_n_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			res_n_prev_reg <= res_n;
			if (state_next == st_proc && state_reg != st_proc)
				proc_cnt_reg <= PROC_INTERVAL_CYCLES;
			else if (proc_cnt_reg != PROC_CNT_ZERO)
				proc_cnt_reg <= proc_cnt_reg - PROC_CNT_ONE;
		end
	end

	// straps and reset configuration
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			half_clock_reg <= 1'b0;
			emulation_reg <= 1'b0;
			reset_config_reg <= 16'h0000;
		end else begin
			if (!res_n)
				reset_config_reg <= ad_in;
			if (res_rise) begin
				half_clock_reg <= !half_clock_strap_n;
				emulation_reg <= !emulation_strap0_n && !emulation_strap1_n;
			end
		end
	end

	// internal clock: follows crystal, or crystal divided by two
	wire crystal_rise = crystal_in && !crystal_prev_reg;
	wire int_clk_next = in_hold ? 1'b0 :
		(half_clock_reg ? (int_clk_reg ^ crystal_rise) : crystal_in);
	wire int_rise = int_clk_next && !int_clk_reg;
	wire int_edge = int_clk_next ^ int_clk_reg;

	// power-save clock: toggles every divisor internal clock edges
	wire [DIV_W-1:0] div_limit = (psave_divisor_reg == DIV_ZERO) ? DIV_ONE : psave_divisor_reg;
	wire div_wrap = int_edge && (div_cnt_reg + DIV_ONE >= div_limit);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			crystal_prev_reg <= 1'b0;
			int_clk_reg <= 1'b0;
			div_cnt_reg <= DIV_ZERO;
			psave_clk_reg <= 1'b0;
		end else begin
			crystal_prev_reg <= crystal_in;
			int_clk_reg <= int_clk_next;
			if (in_hold) begin
				div_cnt_reg <= DIV_ZERO;
				psave_clk_reg <= 1'b0;
			end else if (div_wrap) begin
				div_cnt_reg <= DIV_ZERO;
				psave_clk_reg <= !psave_clk_reg;
			end else if (int_edge) begin
				div_cnt_reg <= div_cnt_reg + DIV_ONE;
			end
		end
	end

	// clock selection
	clkout_ctrl_t clkout_ctrl;
	assign clkout_ctrl = clkout_ctrl_t'(system_config_reg[SC_CLKOUT_MSB:SC_CLKOUT_LSB]);
	wire psave_active = system_config_reg[SC_PSAVE_EN_BIT];
	wire psave_exit = psave_active && irq && bus_phase_t3 && int_rise;
	wire core_sel = (psave_active && !psave_exit) ? psave_clk_reg : int_clk_next;
	wire clkout_a_next = clkout_ctrl.a_enable && (clkout_ctrl.a_psave_rate ? psave_clk_reg : int_clk_next);
	wire clkout_b_next = clkout_ctrl.b_enable && (clkout_ctrl.b_psave_rate ? psave_clk_reg : int_clk_next);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			internal_clk <= 1'b0;
			core_clk <= 1'b0;
			periph_clk <= 1'b0;
			clkout_a <= 1'b0;
			clkout_b <= 1'b0;
		end else begin
			internal_clk <= int_clk_next;
			core_clk <= core_sel;
			periph_clk <= core_sel;
			clkout_a <= clkout_a_next;
			clkout_b <= clkout_b_next;
		end
	end

	// reset outputs
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pll_reset <= 1'b1;
			cpu_halt <= 1'b1;
			bus_halt <= 1'b1;
			watchdog_timer_reset <= 1'b1;
			fetch_start <= 1'b0;
			fetch_addr <= RESET_VECTOR;
			upper_select <= 1'b0;
			fetch_wait_states <= RESET_WAIT_STATES;
			pins_tristate <= 1'b0;
		end else begin
			pll_reset <= (state_next == st_hold);
			cpu_halt <= (state_next != st_run);
			bus_halt <= (state_next != st_run);
			watchdog_timer_reset <= (state_next == st_hold);
			fetch_start <= proc_done && res_n;
			fetch_addr <= RESET_VECTOR;
			upper_select <= proc_done && res_n;
			fetch_wait_states <= RESET_WAIT_STATES;
			if (!res_n)
				pins_tristate <= 1'b0;
			else if (res_rise)
				pins_tristate <= !emulation_strap0_n && !emulation_strap1_n;
		end
	end

	// AXI4-Lite slave
	wire aw_hs = s_axi_awvalid && s_axi_awready;
	wire w_hs = s_axi_wvalid && s_axi_wready;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire wr_config = wr_go && (awaddr_reg == ADDR_SYSTEM_CONFIG);
	wire wr_divisor = wr_go && (awaddr_reg == ADDR_PSAVE_DIVISOR);
	wire wr_mapped = (awaddr_reg == ADDR_SYSTEM_CONFIG) || (awaddr_reg == ADDR_PSAVE_DIVISOR) ||
		(awaddr_reg == ADDR_RESET_CONFIG) || (awaddr_reg == ADDR_STATUS);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		end
		return res;
	endfunction : merge

	wire [31:0] config_written = merge(system_config_reg, wdata_reg, wstrb_reg) & SYSTEM_CONFIG_MASK;
	wire [31:0] divisor_written = merge({24'h000000, psave_divisor_reg}, wdata_reg, wstrb_reg);

	status_t status;
	assign status = '{emulation: emulation_reg, half_clock: half_clock_reg, psave_active: psave_active,
		running: (state_reg == st_run), proc_wait: (state_reg == st_proc), reset_hold: in_hold};

	wire rd_mapped = (s_axi_araddr == ADDR_SYSTEM_CONFIG) || (s_axi_araddr == ADDR_PSAVE_DIVISOR) ||
		(s_axi_araddr == ADDR_RESET_CONFIG) || (s_axi_araddr == ADDR_STATUS);
	wire [31:0] rd_data = (s_axi_araddr == ADDR_SYSTEM_CONFIG) ? system_config_reg :
		(s_axi_araddr == ADDR_PSAVE_DIVISOR) ? {24'h000000, psave_divisor_reg} :
		(s_axi_araddr == ADDR_RESET_CONFIG) ? {16'h0000, reset_config_reg} :
		(s_axi_araddr == ADDR_STATUS) ? {26'h0000000, status} : 32'h00000000;

	// registers; reset pin low reloads defaults, interrupt exit clears power-save enable
	always_ff @(posedge clk_sys) begin
		if (reset || !res_n) begin
			system_config_reg <= SYSTEM_CONFIG_DEFAULT;
			psave_divisor_reg <= PSAVE_DIVISOR_DEFAULT;
		end else begin
			if (wr_config)
				system_config_reg <= config_written;
			if (psave_exit)
				system_config_reg[SC_PSAVE_EN_BIT] <= 1'b0;
			if (wr_divisor)
				psave_divisor_reg <= divisor_written[DIV_W-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_RESP_OKAY;
			awaddr_reg <= '0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
		end else begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				awaddr_reg <= s_axi_awaddr;
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= AXI_RESP_OKAY;
		end else begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_mapped ? AXI_RESP_OKAY : AXI_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule : clock_powersave_reset_ctrl

/* File: clock_powersave_reset_pkg.sv */
// constants, field layouts and types for the clock, power-save and reset controller
// assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus
package clock_powersave_reset_pkg;

	localparam int unsigned CLK_SYS_MHZ = 200;
	localparam int unsigned CLK_SYS_PERIOD_NS = 5;

	// shortest power-on reset low time expected from outside, in ms
	localparam int unsigned POR_MIN_MS = 1;

	// internal processing interval between reset release and first fetch, in ns
	localparam int unsigned PROC_INTERVAL_NS = 100;
	localparam int unsigned PROC_INTERVAL_CYCLES_I =
		(PROC_INTERVAL_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
	localparam int unsigned PROC_CNT_W = 8;
	localparam logic [PROC_CNT_W-1:0] PROC_INTERVAL_CYCLES = PROC_CNT_W'(PROC_INTERVAL_CYCLES_I);
	localparam logic [PROC_CNT_W-1:0] PROC_CNT_ZERO = 8'h00;
	localparam logic [PROC_CNT_W-1:0] PROC_CNT_ONE = 8'h01;

	// register byte offsets
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_SYSTEM_CONFIG = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_PSAVE_DIVISOR = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_RESET_CONFIG = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;

	// system_config_register fields
	localparam int unsigned SC_PSAVE_EN_BIT = 0;
	localparam int unsigned SC_CLKOUT_LSB = 8;
	localparam int unsigned SC_CLKOUT_MSB = 11;
	localparam logic [31:0] SYSTEM_CONFIG_DEFAULT = 32'h0000_0500;
	localparam logic [31:0] SYSTEM_CONFIG_MASK = 32'h0000_0f01;

	// power-save divisor, counts internal clock half periods
	localparam int unsigned DIV_W = 8;
	localparam logic [DIV_W-1:0] PSAVE_DIVISOR_DEFAULT = 8'h04;
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

	// first fetch after reset
	localparam logic [19:0] RESET_VECTOR = 20'hffff0;
	localparam logic [1:0] RESET_WAIT_STATES = 2'h3;

	localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
	localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

	// bits 11..8 of system_config_register
	typedef struct packed {
		logic b_psave_rate;
		logic b_enable;
		logic a_psave_rate;
		logic a_enable;
	} clkout_ctrl_t;

	// status register, low bits
	typedef struct packed {
		logic emulation;
		logic half_clock;
		logic psave_active;
		logic running;
		logic proc_wait;
		logic reset_hold;
	} status_t;

	typedef enum logic [2:0] {
		st_hold = 3'b001,
		st_proc = 3'b010,
		st_run = 3'b100
	} rst_state_t;

endpackage : clock_powersave_reset_pkg

/* File: crystal_por_model.sv */
// crystal oscillator and power-on reset circuit driving the controller
// assumes por_req from the bench starts a power-on reset, clk_sys 200 MHz
`timescale 1ns/10ps
module crystal_por_model #(
	parameter int POR_CYCLES = 40
) (
	input wire logic clk_sys,
	input wire logic por_req,
	output logic crystal_in,
	output logic res_n
);
	int div_cnt = 0;
	int por_cnt = 0;
	logic crystal_reg = 1'b0;
	logic res_n_reg = 1'b0;
	assign crystal_in = crystal_reg;
	assign res_n = res_n_reg;
	// oscillator runs free, half period 3 cycles
	always @(posedge clk_sys) begin
		div_cnt <= (div_cnt == 2) ? 0 : div_cnt + 1;
		if (div_cnt == 2) crystal_reg <= !crystal_reg;
	end
	// scaled minimum low time after por_req falls
	always @(posedge clk_sys) begin
		if (por_req) por_cnt <= POR_CYCLES;
		else if (por_cnt != 0) por_cnt <= por_cnt - 1;
		res_n_reg <= !por_req && por_cnt == 0;
	end
endmodule : crystal_por_model

/* File: clock_powersave_reset_sva.sv */
// checker for reset sequencing, first fetch and clock relations
// assumes binding into clock_powersave_reset_ctrl, single clk_sys domain
`timescale 1ns/10ps
module clock_powersave_reset_sva
	import clock_powersave_reset_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic res_n,
	input wire logic emulation_strap0_n,
	input wire logic emulation_strap1_n,
	input wire logic irq,
	input wire logic bus_phase_t3,
	input wire logic internal_clk,
	input wire logic core_clk,
	input wire logic periph_clk,
	input wire logic pll_reset,
	input wire logic cpu_halt,
	input wire logic bus_halt,
	input wire logic watchdog_timer_reset,
	input wire logic fetch_start,
	input wire logic [19:0] fetch_addr,
	input wire logic upper_select,
	input wire logic [1:0] fetch_wait_states,
	input wire logic pins_tristate
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_pll_hold;
		!res_n |=> pll_reset;
	endproperty
	a_pll_hold: assert property (p_pll_hold) else $error("pll not held");
	property p_halt;
		!res_n |=> cpu_halt && bus_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt in reset");
	property p_halt_interval;
		$rose(res_n) ##1 res_n [*8] |-> cpu_halt && bus_halt && !fetch_start;
	endproperty
	a_halt_interval: assert property (p_halt_interval) else $error("fetch too early");
	property p_wdt;
		!res_n |=> watchdog_timer_reset;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not reset");
	property p_fetch;
		fetch_start |-> upper_select && fetch_addr == RESET_VECTOR
			&& fetch_wait_states == RESET_WAIT_STATES && !cpu_halt ##1 !fetch_start;
	endproperty
	a_fetch: assert property (p_fetch) else $error("bad first fetch");
	property p_emul;
		$rose(res_n) |=> pins_tristate == $past(!emulation_strap0_n && !emulation_strap1_n);
	endproperty
	a_emul: assert property (p_emul) else $error("bad emulation entry");
	property p_same_rate;
		core_clk == periph_clk;
	endproperty
	a_same_rate: assert property (p_same_rate) else $error("core and periph differ");
	property p_exit;
		(irq && bus_phase_t3 && res_n) [*8] |-> core_clk == internal_clk;
	endproperty
	a_exit: assert property (p_exit) else $error("no power-save exit");
	c_fetch: cover property (fetch_start);
	c_emul: cover property ($rose(pins_tristate));
	c_exit: cover property ((irq && bus_phase_t3) [*8]);
endmodule : clock_powersave_reset_sva
bind clock_powersave_reset_ctrl clock_powersave_reset_sva i_clock_powersave_reset_sva (.*);

/* File: clock_powersave_reset_ctrl_tb.sv */
// self-checking bench for the clock, power-save and reset controller
// assumes crystal_por_model as far side, registers reached over AXI4-Lite
`timescale 1ns/10ps
module clock_powersave_reset_ctrl_tb;
	import clock_powersave_reset_pkg::*;
	logic clk_sys = 0, reset = 1, por_req = 1, irq = 0, bus_phase_t3 = 0;
	logic half_clock_strap_n = 1, emulation_strap0_n = 1, emulation_strap1_n = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [15:0] ad_in = 16'h5a3c;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic internal_clk, core_clk, periph_clk, clkout_a, clkout_b, pll_reset, cpu_halt, bus_halt;
	logic watchdog_timer_reset, fetch_start, upper_select, pins_tristate, crystal_in, res_n;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [19:0] fetch_addr;
	logic [1:0] fetch_wait_states, s_axi_bresp, s_axi_rresp;
	int fail_count = 0, checks = 0, na, nb, nc, ni;
	always #2.5 clk_sys = !clk_sys;
	crystal_por_model i_crystal_por_model (.*);
	clock_powersave_reset_ctrl i_clock_powersave_reset_ctrl (.*);
	task complete_run;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk_sys);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		if (n == 50) begin fail_count++; complete_run; end
		s_axi_bready <= 0;
		chk(32'(s_axi_bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clk_sys);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		if (n == 50) begin fail_count++; complete_run; end
		s_axi_rready <= 0;
		chk(s_axi_rdata, ed);
		chk(32'(s_axi_rresp), 32'(er));
	endtask : rd
	// counts toggles over 48 cycles, optionally checks clock follows crystal
	task automatic meas(input logic f);
		logic pa, pb, pc, pi, px;
		na = 0; nb = 0; nc = 0; ni = 0;
		@(posedge clk_sys);
		{pa, pb, pc, pi, px} = {clkout_a, clkout_b, core_clk, internal_clk, crystal_in};
		repeat (48) begin
			@(posedge clk_sys);
			if (f) chk(32'(internal_clk), 32'(px));
			chk(32'(periph_clk), 32'(core_clk));
			na += int'(clkout_a != pa); nb += int'(clkout_b != pb);
			nc += int'(core_clk != pc); ni += int'(internal_clk != pi);
			{pa, pb, pc, pi, px} = {clkout_a, clkout_b, core_clk, internal_clk, crystal_in};
		end
	endtask : meas
	task automatic t_por(input logic h, input logic [1:0] e);
		int n;
		@(posedge clk_sys);
		por_req <= 1; half_clock_strap_n <= h; {emulation_strap1_n, emulation_strap0_n} <= e; ad_in <= 16'h5a3c;
		repeat (4) @(posedge clk_sys);
		por_req <= 0;
		chk(32'(pll_reset), 32'h1);
		chk(32'({cpu_halt, bus_halt, watchdog_timer_reset}), 32'h7);
		for (n = 0; n < 100 && !res_n; n++) @(posedge clk_sys);
		if (!res_n) begin fail_count++; complete_run; end
		{half_clock_strap_n, emulation_strap1_n, emulation_strap0_n} <= 3'h7; ad_in <= 16'h0f0f;
		for (n = 0; n < 40 && !fetch_start; n++) @(posedge clk_sys);
		if (!fetch_start) begin fail_count++; complete_run; end
		chk(32'(fetch_start), 32'h1);
		chk(32'({pll_reset, watchdog_timer_reset}), 32'h0);
		chk(32'({upper_select, fetch_addr, fetch_wait_states, cpu_halt, bus_halt}),
			32'({1'b1, RESET_VECTOR, RESET_WAIT_STATES, 2'b00}));
		chk(32'(pins_tristate), 32'(e == 2'b00));
		rd(ADDR_STATUS, 32'({e == 2'b00, !h, 4'h4}), AXI_RESP_OKAY);
		rd(ADDR_SYSTEM_CONFIG, SYSTEM_CONFIG_DEFAULT, AXI_RESP_OKAY);
		rd(ADDR_PSAVE_DIVISOR, 32'(PSAVE_DIVISOR_DEFAULT), AXI_RESP_OKAY);
		rd(ADDR_RESET_CONFIG, 32'h5a3c, AXI_RESP_OKAY);
		meas(h);
		chk(32'(h ? (ni >= 15 && ni <= 17) : (ni >= 7 && ni <= 9)), 32'h1);
	endtask : t_por
	task automatic t_clkout;
		wr(ADDR_SYSTEM_CONFIG, 32'h0100, AXI_RESP_OKAY);
		meas(0);
		chk(32'({na == ni, nb == 0}), 32'h3);
		wr(ADDR_SYSTEM_CONFIG, 32'h0400, AXI_RESP_OKAY);
		meas(0);
		chk(32'({na == 0, nb == ni}), 32'h3);
		wr(ADDR_PSAVE_DIVISOR, 32'h2, AXI_RESP_OKAY);
		rd(ADDR_PSAVE_DIVISOR, 32'h2, AXI_RESP_OKAY);
		wr(ADDR_SYSTEM_CONFIG, 32'h0701, AXI_RESP_OKAY);
		meas(0);
		chk(32'({nb == ni, na > 0, na < nb}), 32'h7);
		wr(ADDR_SYSTEM_CONFIG, 32'h0d01, AXI_RESP_OKAY);
		meas(0);
		chk(32'({na == ni, nb > 0, nb < na}), 32'h7);
		chk(32'({nc > 0, nc < ni}), 32'h3);
	endtask : t_clkout
	task automatic t_psave_exit;
		@(posedge clk_sys);
		irq <= 1;
		repeat (12) @(posedge clk_sys);
		rd(ADDR_SYSTEM_CONFIG, 32'h0d01, AXI_RESP_OKAY);
		bus_phase_t3 <= 1;
		repeat (12) @(posedge clk_sys);
		rd(ADDR_SYSTEM_CONFIG, 32'h0d00, AXI_RESP_OKAY);
		meas(0);
		chk(32'(nc == ni), 32'h1);
		irq <= 0; bus_phase_t3 <= 0;
	endtask : t_psave_exit
	task automatic t_unmapped;
		wr(8'h10, 32'hffff_ffff, AXI_RESP_SLVERR);
		rd(8'h10, 32'h0, AXI_RESP_SLVERR);
		wr(ADDR_RESET_CONFIG, 32'hffff, AXI_RESP_OKAY);
		rd(ADDR_RESET_CONFIG, 32'h5a3c, AXI_RESP_OKAY);
	endtask : t_unmapped
	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 0;
		t_por(1'b1, 2'b11);
		t_clkout;
		t_psave_exit;
		t_unmapped;
		t_por(1'b0, 2'b00);
		t_por(1'b1, 2'b01);
		complete_run;
	end
endmodule : clock_powersave_reset_ctrl_tb
